// File: verilog/fsp_pkg.sv
// constants shared by the flash status and protect mode host controller
package fsp_pkg;

  // ---------------------------------------------------------------------
  // apb register map (byte offsets)
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CONFIG = 8'h14;

  // status and config bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REDO = 2;
  localparam int ST_ERASE = 3;
  localparam int ST_REFUSED = 4;
  localparam int CFG_WP = 0;
  localparam logic CFG_WP_RESET = 1'b1;

  // ---------------------------------------------------------------------
  // command codes written to the command register
  // ---------------------------------------------------------------------
  localparam logic [3:0] CMD_READ = 4'h0;
  localparam logic [3:0] CMD_PROG = 4'h1;
  localparam logic [3:0] CMD_SECT = 4'h2;
  localparam logic [3:0] CMD_BLK = 4'h3;
  localparam logic [3:0] CMD_CHIP = 4'h4;
  localparam logic [3:0] CMD_SUSP = 4'h5;
  localparam logic [3:0] CMD_RESUME = 4'h6;
  localparam logic [3:0] CMD_ID = 4'h7;
  localparam logic [3:0] CMD_CFIV = 4'h8;
  localparam logic [3:0] CMD_CFIG = 4'h9;
  localparam logic [3:0] CMD_SECID = 4'ha;
  localparam logic [3:0] CMD_EXIT = 4'hb;
  localparam logic [3:0] CMD_SECX = 4'hc;
  localparam logic [3:0] CMD_HRESET = 4'hd;

  // ---------------------------------------------------------------------
  // flash bus cycle addresses and data
  // ---------------------------------------------------------------------
  localparam logic [19:0] A_5555 = 20'h05555;
  localparam logic [19:0] A_2AAA = 20'h02aaa;
  localparam logic [19:0] A_0055 = 20'h00055;
  localparam logic [15:0] D_AA = 16'h00aa;
  localparam logic [15:0] D_55 = 16'h0055;
  localparam logic [15:0] D_A0 = 16'h00a0;
  localparam logic [15:0] D_80 = 16'h0080;
  localparam logic [15:0] D_10 = 16'h0010;
  localparam logic [15:0] D_30 = 16'h0030;
  localparam logic [15:0] D_50 = 16'h0050;
  localparam logic [15:0] D_B0 = 16'h00b0;
  localparam logic [15:0] D_98 = 16'h0098;
  localparam logic [15:0] D_88 = 16'h0088;
  localparam int TOGGLE_BIT = 6;
  localparam int SUSP_TOGGLE_BIT = 2;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int WE_LOW_NS = 30;
  localparam int WE_HIGH_NS = 30;
  localparam int RD_ACC_NS = 70;
  localparam int RD_HIGH_NS = 20;
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_ACC_CYC = (RD_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_HIGH_CYC = (RD_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 3;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_WSET = 4'b0001,
    S_WLOW = 4'b0010,
    S_WHIGH = 4'b0011,
    S_RSET = 4'b0100,
    S_RACC = 4'b0101,
    S_RCAP = 4'b0110,
    S_RHIGH = 4'b0111,
    S_RLOW = 4'b1000,
    S_RWAIT = 4'b1001
  } fsp_state_t;

endpackage

// File: verilog/fsp_host.sv
// host controller driving a parallel nor flash through its pins
//
// What this block does
// - poll reads use the operation's own address
// - wait reset_to_read_delay before next access
// - aborted program, erase or resume flagged for reissue
// - every program and erase gets its unlock
// - vendor query entry ends 98h at 5555h
// - general query entry writes 98h at 55h
// - completion found by toggle bits only
// - security id entry ends 88h at 5555h
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/10ps
module fsp_host import fsp_pkg::*; #(
  parameter int RESET_PULSE_MIN_NS = 500,
  parameter int RESET_TO_READ_DELAY_NS = 200,
  parameter logic [15:0] ID_ENTRY_CODE = 16'h0001, // arbitrary value
  parameter logic [15:0] ID_EXIT_CODE = 16'h0002, // arbitrary value
  parameter logic [15:0] SECID_EXIT_CODE = 16'h0003 // arbitrary value
) (
  input wire logic mclk, // system clock
  input wire logic reset_n, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic [19:0] fl_addr, // flash address
  input wire logic [15:0] fl_dq_in, // flash data from pins
  output logic [15:0] fl_dq_out, // flash data to pins
  output logic fl_dq_oe, // flash data drive enable
  output logic fl_ce_n, // flash chip select
  output logic fl_oe_n, // flash output enable
  output logic fl_we_n, // flash write strobe
  output logic fl_wp_n, // flash boot block protect
  output logic fl_rst_n // flash hard reset
);

  // ---------------------------------------------------------------------
  // derived reset timing
  // ---------------------------------------------------------------------
  localparam int RP_RAW = (RESET_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RHR_RAW = (RESET_TO_READ_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC = (RP_RAW < 1) ? 1 : RP_RAW;
  localparam int RHR_CYC = (RHR_RAW < 1) ? 1 : RHR_RAW;

  fsp_state_t st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [2:0] step_q, step_d;
  logic [3:0] op_cmd_q;
  logic [19:0] op_addr_q, taddr_q;
  logic [15:0] op_data_q, tdata_q, rdata_q, rdata_d, prev_q, prev_d;
  logic first_q, first_d, fin_q, fin_d;
  logic done_q, redo_q, erase_q, refused_q, wp_q;
  logic set_done, set_redo, set_erase;
  logic [19:0] addr_q, addr_d;
  logic [15:0] dqo_q, dqo_d;
  logic oe_q, oe_d, ce_q, ce_d, rd_q, rd_d, we_q, we_d, rst_q, rst_d;
  logic [15:0] s1_q, s2_q, s3_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;

  // ---------------------------------------------------------------------
  // sequence tables
  // ---------------------------------------------------------------------
  function automatic logic [35:0] seq_word(input logic [3:0] c,
      input logic [2:0] s, input logic [19:0] a, input logic [15:0] d);
    logic [35:0] w;
    w = {A_5555, D_AA};
    if (s == 3'd1) w = {A_2AAA, D_55};
    case (c)
      CMD_PROG: begin
        if (s == 3'd2) w = {A_5555, D_A0};
        else if (s == 3'd3) w = {a, d};
      end
      CMD_SECT, CMD_BLK, CMD_CHIP: begin
        if (s == 3'd2) w = {A_5555, D_80};
        else if (s == 3'd4) w = {A_2AAA, D_55};
        else if (s == 3'd5) w = (c == CMD_SECT) ? {a, D_30} :
                                (c == CMD_BLK) ? {a, D_50} : {A_5555, D_10};
      end
      CMD_SUSP: w = {a, D_B0};
      CMD_RESUME: w = {a, D_30};
      CMD_ID: if (s == 3'd2) w = {A_5555, ID_ENTRY_CODE};
      CMD_CFIV: if (s == 3'd2) w = {A_5555, D_98};
      CMD_CFIG: w = {A_0055, D_98};
      CMD_SECID: if (s == 3'd2) w = {A_5555, D_88};
      CMD_EXIT: w = {a, ID_EXIT_CODE};
      CMD_SECX: w = {a, SECID_EXIT_CODE};
      default: ;
    endcase
    return w;
  endfunction

  function automatic logic [2:0] seq_len(input logic [3:0] c);
    logic [2:0] n;
    case (c)
      CMD_PROG: n = 3'd4;
      CMD_SECT, CMD_BLK, CMD_CHIP: n = 3'd6;
      CMD_ID, CMD_CFIV, CMD_SECID: n = 3'd3;
      default: n = 3'd1;
    endcase
    return n;
  endfunction

  // ---------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------
  wire acc = psel & penable & ~pready_q;
  wire wr = acc & pwrite;
  wire hit_cmd = (paddr == OFS_CMD);
  wire hit_addr = (paddr == OFS_ADDR);
  wire hit_wdata = (paddr == OFS_WDATA);
  wire hit_rdata = (paddr == OFS_RDATA);
  wire hit_stat = (paddr == OFS_STATUS);
  wire hit_cfg = (paddr == OFS_CONFIG);
  wire hit_any = hit_cmd | hit_addr | hit_wdata | hit_rdata | hit_stat
                 | hit_cfg;
  wire idle = (st_q == S_IDLE);
  wire cmd_wr = wr & hit_cmd;
  wire [3:0] new_cmd = pwdata[3:0];
  wire rst_req = cmd_wr & (new_cmd == CMD_HRESET);
  wire accept = cmd_wr & idle & ~rst_req;
  wire refuse = cmd_wr & ~idle & ~rst_req;
  wire stat_clr = wr & hit_stat;
  wire [31:0] status_w = {27'h0000000, refused_q, erase_q, redo_q, done_q,
                          ~idle};
  wire [31:0] rd_mux = hit_addr ? {12'h000, taddr_q} :
                       hit_wdata ? {16'h0000, tdata_q} :
                       hit_rdata ? {16'h0000, rdata_q} :
                       hit_stat ? status_w :
                       hit_cfg ? {31'h00000000, wp_q} : 32'h00000000;

  // ---------------------------------------------------------------------
  // sequence helpers
  // ---------------------------------------------------------------------
  wire [35:0] sw = seq_word(op_cmd_q, step_q, op_addr_q, op_data_q);
  wire last_step = (step_q == 3'(seq_len(op_cmd_q) - 3'd1));
  wire poll_op = (op_cmd_q == CMD_PROG) | (op_cmd_q == CMD_SECT) |
                 (op_cmd_q == CMD_BLK) | (op_cmd_q == CMD_CHIP) |
                 (op_cmd_q == CMD_RESUME);
  wire sync_ok = (s2_q == s3_q);
  wire tog_same = (s3_q[TOGGLE_BIT] == prev_q[TOGGLE_BIT]);
  wire susp_tog = (s3_q[SUSP_TOGGLE_BIT] != prev_q[SUSP_TOGGLE_BIT]);

  // ---------------------------------------------------------------------
  // flash cycle state machine
  // ---------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = 16'(cnt_q + 16'h0001);
    step_d = step_q;
    addr_d = addr_q;
    dqo_d = dqo_q;
    oe_d = oe_q;
    ce_d = 1'b1;
    rd_d = 1'b1;
    we_d = 1'b1;
    rst_d = 1'b1;
    rdata_d = rdata_q;
    prev_d = prev_q;
    first_d = first_q;
    fin_d = fin_q;
    set_done = 1'b0;
    set_erase = 1'b0;
    set_redo = 1'b0;
    case (st_q)
      S_IDLE: begin
        oe_d = 1'b0;
        cnt_d = 16'h0000;
        step_d = 3'd0;
        first_d = 1'b1;
        fin_d = 1'b0;
        if (accept) begin
          st_d = (new_cmd == CMD_READ) ? S_RSET : S_WSET;
        end
      end
      S_WSET: begin
        addr_d = sw[35:16];
        dqo_d = sw[15:0]; // upper byte of codes is zero
        oe_d = 1'b1;
        cnt_d = 16'h0000;
        st_d = S_WLOW;
      end
      S_WLOW: begin
        ce_d = 1'b0;
        we_d = 1'b0; // read strobe stays high
        if (cnt_q == 16'(WE_LOW_CYC)) begin
          ce_d = 1'b1;
          we_d = 1'b1;
          cnt_d = 16'h0000;
          st_d = S_WHIGH;
        end
      end
      S_WHIGH: begin
        if (cnt_q == 16'(WE_HIGH_CYC - 1)) begin
          if (!last_step) begin
            step_d = 3'(step_q + 3'd1);
            st_d = S_WSET;
          end else if (poll_op) begin
            st_d = S_RSET; // poll after last pulse
          end else begin
            set_done = 1'b1;
            st_d = S_IDLE;
          end
        end
      end
      S_RSET: begin
        addr_d = op_addr_q; // poll at the operation address
        oe_d = 1'b0;
        cnt_d = 16'h0000;
        st_d = S_RACC;
      end
      S_RACC: begin
        ce_d = 1'b0;
        rd_d = 1'b0;
        if (cnt_q == 16'(RD_ACC_CYC - 1)) begin
          cnt_d = 16'h0000;
          st_d = S_RCAP;
        end
      end
      S_RCAP: begin
        ce_d = 1'b0;
        rd_d = 1'b0;
        if (cnt_q >= 16'(SYNC_CYC - 1) && sync_ok) begin
          ce_d = 1'b1;
          rd_d = 1'b1;
          cnt_d = 16'h0000;
          rdata_d = s3_q;
          prev_d = s3_q;
          first_d = 1'b0;
          fin_d = ~poll_op | (~first_q & tog_same);
          set_erase = poll_op & ~first_q & susp_tog;
          st_d = S_RHIGH;
        end
      end
      S_RHIGH: begin
        if (cnt_q == 16'(RD_HIGH_CYC - 1)) begin
          cnt_d = 16'h0000;
          if (fin_q) begin
            set_done = 1'b1;
            st_d = S_IDLE;
          end else begin
            st_d = S_RSET;
          end
        end
      end
      S_RLOW: begin
        rst_d = 1'b0;
        if (cnt_q == 16'(RP_CYC - 1)) begin
          rst_d = 1'b1;
          cnt_d = 16'h0000;
          st_d = S_RWAIT;
        end
      end
      S_RWAIT: begin
        if (cnt_q == 16'(RHR_CYC - 1)) begin
          set_done = 1'b1;
          st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
    if (rst_req) begin
      set_redo = ~idle & poll_op & (st_q != S_RLOW) &
                 (st_q != S_RWAIT);
      set_done = 1'b0;
      oe_d = 1'b0;
      ce_d = 1'b1;
      rd_d = 1'b1;
      we_d = 1'b1;
      rst_d = 1'b0;
      cnt_d = 16'h0000;
      st_d = S_RLOW;
    end
  end

  // state machine and pin registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= S_IDLE;
      cnt_q <= 16'h0000;
      step_q <= 3'd0;
      addr_q <= 20'h00000;
      dqo_q <= 16'h0000;
      oe_q <= 1'b0;
      ce_q <= 1'b1;
      rd_q <= 1'b1;
      we_q <= 1'b1;
      rst_q <= 1'b1;
      rdata_q <= 16'h0000;
      prev_q <= 16'h0000;
      first_q <= 1'b1;
      fin_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      step_q <= step_d;
      addr_q <= addr_d;
      dqo_q <= dqo_d;
      oe_q <= oe_d;
      ce_q <= ce_d;
      rd_q <= rd_d;
      we_q <= we_d;
      rst_q <= rst_d;
      rdata_q <= rdata_d;
      prev_q <= prev_d;
      first_q <= first_d;
      fin_q <= fin_d;
    end
  end

  // three stage data synchroniser
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 16'h0000;
      s2_q <= 16'h0000;
      s3_q <= 16'h0000;
    end else begin
      s1_q <= fl_dq_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ---------------------------------------------------------------------
  // software registers; hardware set wins over clear
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      taddr_q <= 20'h00000;
      tdata_q <= 16'h0000;
      wp_q <= CFG_WP_RESET;
      op_cmd_q <= CMD_READ;
      op_addr_q <= 20'h00000;
      op_data_q <= 16'h0000;
      done_q <= 1'b0;
      redo_q <= 1'b0;
      erase_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      if (wr & hit_addr) taddr_q <= pwdata[19:0];
      if (wr & hit_wdata) tdata_q <= pwdata[15:0];
      if (wr & hit_cfg) wp_q <= pwdata[CFG_WP];
      if (accept) begin
        op_cmd_q <= new_cmd;
        op_addr_q <= taddr_q;
        op_data_q <= tdata_q;
      end
      done_q <= set_done | (done_q & ~(stat_clr & pwdata[ST_DONE]));
      redo_q <= set_redo | (redo_q & ~(stat_clr & pwdata[ST_REDO]));
      erase_q <= set_erase | (erase_q & ~(stat_clr & pwdata[ST_ERASE]));
      refused_q <= refuse | (refused_q & ~(stat_clr & pwdata[ST_REFUSED]));
    end
  end

  // apb answer, one wait cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= acc;
      pslverr_q <= acc & ~hit_any;
      if (acc & ~pwrite) prdata_q <= rd_mux;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign fl_addr = addr_q;
  assign fl_dq_out = dqo_q;
  assign fl_dq_oe = oe_q;
  assign fl_ce_n = ce_q;
  assign fl_oe_n = rd_q;
  assign fl_we_n = we_q;
  assign fl_wp_n = wp_q;
  assign fl_rst_n = rst_q;

endmodule

// File: sim/fsp_host_assertions.sv
// pin and bus checker for the flash host controller
`timescale 1ns/10ps
module fsp_host_chk #(
  parameter int RESET_PULSE_MIN_NS = 500,
  parameter int RESET_TO_READ_DELAY_NS = 200
) (
  input wire logic mclk, // clock
  input wire logic reset_n, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [15:0] fl_dq_out, // data to pins
  input wire logic fl_dq_oe, // data drive
  input wire logic fl_ce_n, // chip select
  input wire logic fl_oe_n, // output enable
  input wire logic fl_we_n, // write strobe
  input wire logic fl_rst_n // flash reset
);
  // ---------------------------------------------------------------
  // cycle counters around the flash reset pin
  // ---------------------------------------------------------------
  localparam int RP_CYC = (RESET_PULSE_MIN_NS + 9) / 10;
  localparam int RR_CYC = (RESET_TO_READ_DELAY_NS + 9) / 10;
  logic [7:0] lo_q, lo_d, hi_q, hi_d;
  assign lo_d = fl_rst_n ? 8'h00 : lo_q + 8'h01;
  assign hi_d = !fl_rst_n ? 8'h00 : (hi_q == 8'hff ? hi_q : hi_q + 8'h01);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lo_q <= 8'h00;
      hi_q <= 8'hff;
    end else begin
      lo_q <= lo_d;
      hi_q <= hi_d;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  sequence we_low_s;
    !fl_we_n [*3] ##1 fl_we_n;
  endsequence
  apb_wait_a: assert property (acc_s |=> pready)
    else $error("apb ready missing after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("apb ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("apb error without ready");
  write_inhibit_a: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n)
    else $error("write strobe low outside a write");
  we_width_a: assert property ($fell(fl_we_n) |-> we_low_s)
    else $error("write strobe pulse has wrong length");
  upper_byte_a: assert property (fl_dq_oe && fl_dq_out[7:0] == 8'haa
    |-> fl_dq_out[15:8] == 8'h00)
    else $error("upper data byte not zero in unlock");
  reset_pulse_a: assert property ($rose(fl_rst_n) |-> lo_q >= RP_CYC)
    else $error("flash reset pulse too short");
  reset_read_a: assert property ($fell(fl_ce_n) |-> hi_q >= RR_CYC)
    else $error("flash access too soon after reset");
endmodule

bind fsp_host fsp_host_chk #(
  .RESET_PULSE_MIN_NS(RESET_PULSE_MIN_NS),
  .RESET_TO_READ_DELAY_NS(RESET_TO_READ_DELAY_NS)
) fsp_host_chk_i (
  .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .fl_dq_out(fl_dq_out),
  .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
  .fl_we_n(fl_we_n), .fl_rst_n(fl_rst_n)
);

// File: sim/fsp_flash_model.sv
// behavioural parallel nor flash answering the host controller
`timescale 1ns/10ps
module fsp_flash_model import fsp_pkg::*; #(
  parameter int BUSY_READS = 6,
  parameter logic [15:0] MAKER = 16'h005a, // arbitrary value
  parameter logic [15:0] PART = 16'h00a5 // arbitrary value
) (
  input wire logic [19:0] fl_addr, // address pins
  input wire logic [15:0] fl_dq_out, // data from the host
  input wire logic fl_ce_n, // chip select
  input wire logic fl_oe_n, // output enable
  input wire logic fl_we_n, // write strobe
  input wire logic fl_wp_n, // boot block protect
  input wire logic fl_rst_n, // hard reset
  output logic [15:0] mdl_dq // data toward the host
);
  logic [15:0] mem [logic [19:0]];
  logic [15:0] rd_q = 16'hffff, ent_d_q, last_d_q, pd_q;
  logic [19:0] ent_a_q;
  logic [7:0] d;
  logic busy_q = 1'b0, mode_q = 1'b0, ers_q, tog_q, arm_p, arm_e;
  int n_q = 0, left_q, alter_cnt = 0, rst_cnt = 0;
  realtime tf = 0;

  // ---------------------------------------------------------------
  // released bus shows the inverse of the last value
  // ---------------------------------------------------------------
  assign mdl_dq = (!fl_ce_n && !fl_oe_n) ? rd_q : ~rd_q;
  // write ends on the first of ce_n and we_n to rise
  wire wr_n = fl_ce_n | fl_we_n;
  wire rd_n = fl_ce_n | fl_oe_n;
  always @(negedge wr_n) tf = $realtime;

  // reads, command writes and hard reset
  always @(posedge wr_n or negedge rd_n or negedge fl_rst_n) begin
    if (!fl_rst_n) begin
      busy_q = 1'b0;
      mode_q = 1'b0;
      n_q = 0;
      rst_cnt++;
    end else if (!rd_n) begin
      if (busy_q) begin
        tog_q = ~tog_q;
        rd_q = {8'h00, !ers_q & ~pd_q[7], tog_q, 3'b000,
                ers_q & tog_q, 2'b00};
        left_q--;
        busy_q = (left_q != 0);
      end else if (mode_q) begin
        rd_q = fl_addr[0] ? PART : MAKER;
      end else begin
        rd_q = mem.exists(fl_addr) ? mem[fl_addr] : 16'hffff;
      end
    end else if (fl_oe_n && !busy_q
                 && $realtime - tf >= 5.0) begin
      d = fl_dq_out[7:0]; // upper byte ignored
      last_d_q = fl_dq_out;
      n_q++;
      if (n_q == 1 && d == 8'h98 && fl_addr == A_0055) begin
        ent_d_q = fl_dq_out;
        ent_a_q = fl_addr;
        mode_q = 1'b1;
        n_q = 0;
      end else if (n_q == 1 && d != 8'haa) begin
        mode_q = 1'b0;
        n_q = 0;
      end else if ((n_q == 2 || n_q == 5) && d != 8'h55 ||
                   n_q == 4 && arm_e && d != 8'haa) begin
        n_q = 0;
      end else if (n_q == 3) begin
        arm_p = (d == 8'ha0);
        arm_e = (d == 8'h80);
        if (!arm_p && !arm_e) begin
          ent_d_q = fl_dq_out;
          ent_a_q = fl_addr;
          mode_q = 1'b1;
          n_q = 0;
        end
      end else if (n_q == 4 && arm_p || n_q == 6) begin
        n_q = 0;
        ers_q = !arm_p;
        if (fl_wp_n || fl_addr >= 20'h08000 && !(ers_q && d == 8'h10)) begin
          busy_q = 1'b1;
          left_q = BUSY_READS;
          tog_q = 1'b0;
          pd_q = fl_dq_out;
          alter_cnt++;
          if (!ers_q) begin
            mem[fl_addr] = fl_dq_out;
          end
        end
      end
    end
  end
endmodule

// File: sim/test_fsp_host.sv
// self-checking bench for the flash host controller
`timescale 1ns/10ps
module test_fsp_host import fsp_pkg::*; ;
  localparam logic [15:0] MAKER = 16'h005a; // arbitrary value
  localparam logic [15:0] PART = 16'h00a5; // arbitrary value
  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, er;
  logic fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_wp_n, fl_rst_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] fl_addr;
  logic [15:0] fl_dq_in, fl_dq_out, mdl_dq;
  int err_total, n_compared;

  // ---------------------------------------------------------------
  // design, flash model and the shared data wire
  // ---------------------------------------------------------------
  assign fl_dq_in = fl_dq_oe ? fl_dq_out : mdl_dq;
  fsp_host #(.RESET_PULSE_MIN_NS(20), .RESET_TO_READ_DELAY_NS(20))
  fsp_host_i (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr),
    .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
    .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .fl_wp_n(fl_wp_n), .fl_rst_n(fl_rst_n));
  fsp_flash_model #(.BUSY_READS(6), .MAKER(MAKER), .PART(PART))
  fsp_flash_model_i (
    .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_wp_n(fl_wp_n),
    .fl_rst_n(fl_rst_n), .mdl_dq(mdl_dq));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // compare, bus cycle and command helpers
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle;
    do xfer(1'b0, OFS_STATUS, 32'h0); while (rd[ST_BUSY] !== 1'b0);
  endtask
  task automatic run(input logic [3:0] c, input logic [19:0] a,
                     input logic [15:0] v);
    xfer(1'b1, OFS_STATUS, 32'h1e);
    xfer(1'b1, OFS_ADDR, {12'h000, a});
    xfer(1'b1, OFS_WDATA, {16'h0000, v});
    xfer(1'b1, OFS_CMD, {28'h0, c});
    wait_idle();
  endtask
  task automatic rdat(input logic [19:0] a);
    run(CMD_READ, a, 16'h0);
    xfer(1'b0, OFS_RDATA, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk("wp pin", {31'h0, fl_wp_n}, 32'h1);
    chk("strobes", {29'h0, fl_ce_n, fl_oe_n, fl_we_n}, 32'h7);
    xfer(1'b0, OFS_CONFIG, 32'h0);
    chk("config", rd, {31'h0, CFG_WP_RESET});
    xfer(1'b0, 8'h18, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask
  task automatic t_prog;
    int n0;
    n0 = fsp_flash_model_i.alter_cnt;
    run(CMD_PROG, 20'h00100, 16'h00c3);
    chk("prog start", fsp_flash_model_i.alter_cnt, n0 + 1);
    chk("prog busy", {31'h0, fsp_flash_model_i.busy_q}, 32'h0);
    chk("prog status", rd & 32'h1f, 32'h2);
    rdat(20'h00100);
    chk("prog data", rd, 32'h00c3);
  endtask
  task automatic t_erase;
    logic [3:0] cd [3] = '{CMD_SECT, CMD_BLK, CMD_CHIP};
    logic [7:0] dd [3] = '{8'h30, 8'h50, 8'h10};
    int n0;
    for (int i = 0; i < 3; i++) begin
      n0 = fsp_flash_model_i.alter_cnt;
      run(cd[i], 20'h10000, 16'h0);
      chk("erase start", fsp_flash_model_i.alter_cnt, n0 + 1);
      chk("erase code", fsp_flash_model_i.last_d_q, {8'h0, dd[i]});
      chk("erase status", rd & 32'h1f, 32'ha);
    end
  endtask
  task automatic t_protect;
    int n0;
    xfer(1'b1, OFS_CONFIG, 32'h0);
    chk("wp low", {31'h0, fl_wp_n}, 32'h0);
    n0 = fsp_flash_model_i.alter_cnt;
    run(CMD_PROG, 20'h00010, 16'h0011);
    chk("boot refused", fsp_flash_model_i.alter_cnt, n0);
    xfer(1'b1, OFS_CONFIG, 32'h1);
  endtask
  task automatic t_modes;
    logic [3:0] en [3] = '{CMD_CFIV, CMD_CFIG, CMD_SECID};
    logic [3:0] ex [3] = '{CMD_EXIT, CMD_EXIT, CMD_SECX};
    logic [19:0] ea [3] = '{A_5555, A_0055, A_5555};
    logic [7:0] ed [3] = '{8'h98, 8'h98, 8'h88};
    for (int i = 0; i < 3; i++) begin
      run(en[i], 20'h0, 16'h0);
      chk("entry addr", fsp_flash_model_i.ent_a_q, ea[i]);
      chk("entry data", fsp_flash_model_i.ent_d_q, ed[i]);
      run(ex[i], 20'h0, 16'h0);
      chk("mode left", fsp_flash_model_i.mode_q, 1'b0);
    end
    run(CMD_ID, 20'h0, 16'h0);
    rdat(20'h00000);
    chk("maker", rd, {16'h0, MAKER});
    rdat(20'h00001);
    chk("part", rd, {16'h0, PART});
    run(CMD_EXIT, 20'h0, 16'h0);
    rdat(20'h00100);
    chk("array back", rd, 32'h00c3);
  endtask
  task automatic t_hreset;
    int n0;
    n0 = fsp_flash_model_i.rst_cnt;
    xfer(1'b1, OFS_STATUS, 32'h1e);
    xfer(1'b1, OFS_ADDR, 32'h00200);
    xfer(1'b1, OFS_WDATA, 32'h0077);
    xfer(1'b1, OFS_CMD, {28'h0, CMD_PROG});
    xfer(1'b1, OFS_CMD, {28'h0, CMD_EXIT});
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk("refused", rd & 32'h11, 32'h11);
    wait (fl_oe_n === 1'b0);
    xfer(1'b1, OFS_CMD, {28'h0, CMD_HRESET});
    wait_idle();
    chk("reset pulse", fsp_flash_model_i.rst_cnt, n0 + 1);
    chk("redo", rd & 32'h1f, 32'h16);
    n0 = fsp_flash_model_i.alter_cnt;
    run(CMD_PROG, 20'h00200, 16'h0077);
    chk("reissue", fsp_flash_model_i.alter_cnt, n0 + 1);
  endtask

  task automatic complete_run;
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence and watchdog
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_total = 0;
    n_compared = 0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_prog();
    t_erase();
    t_protect();
    t_modes();
    t_hreset();
    complete_run();
  end
  initial begin
    #400000;
    err_total++;
    complete_run();
  end
endmodule
